// File: bench/acac_ctrl_assertions.sv
// Checker of the conversion and alert control outputs
module acac_chk #(
	parameter CLK_HZ = 125000000
) (
	input logic mclk,
	input logic resetn,
	input logic cfg_wr,
	input logic cfg_os,
	input logic cfg_mode,
	input logic gcall_rst,
	input logic os_flag,
	input logic powered,
	input logic conv_done,
	input logic [11:0] result,
	input logic alert_o,
	input logic sda_o
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WK = CLK_HZ / 40000;
	int wk_cnt;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ------------
	// Wake counter
	// ------------
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
			wk_cnt <= 0;
		else
			wk_cnt <= os_flag ? wk_cnt + 1 : 0;
	// ------------
	// Properties
	// ------------
	pin_low_a: assert property (!alert_o)
		else $error("alert data bit not low");
	sda_low_a: assert property (!sda_o)
		else $error("reply data bit not low");
	done_once_a: assert property (conv_done |=> !conv_done)
		else $error("done pulse too long");
	done_pwr_a: assert property (conv_done |-> $past(powered))
		else $error("done while powered down");
	wake_pwr_a: assert property (os_flag |-> powered)
		else $error("wake without power");
	os_take_a: assert property ($rose(os_flag) |->
		$past(cfg_wr && cfg_os && cfg_mode && !powered))
		else $error("one-shot taken wrongly");
	wake_len_a: assert property ($fell(os_flag) |->
		(wk_cnt >= WK - 1 && wk_cnt <= WK + 2) || $past(gcall_rst))
		else $error("wake length wrong");
	gcall_off_a: assert property (gcall_rst |=> !powered && !os_flag)
		else $error("general reset left power on");
	res_hold_a: assert property ($changed(result) |->
		conv_done || $past(gcall_rst))
		else $error("result moved off conversion end");
endmodule // acac_chk

bind acac_ctrl acac_chk #(.CLK_HZ(CLK_HZ)) chk_u (
	.mclk(mclk), .resetn(resetn), .cfg_wr(cfg_wr), .cfg_os(cfg_os),
	.cfg_mode(cfg_mode), .gcall_rst(gcall_rst), .os_flag(os_flag),
	.powered(powered), .conv_done(conv_done), .result(result),
	.alert_o(alert_o), .sda_o(sda_o)
);

// File: bench/acac_host_model.sv
// Bus controller model serving the alert response on the link
module acac_host_model (
	input logic mclk,
	input logic sda_oe_n,
	input logic [6:0] rival,
	output logic link_clk,
	output logic sda_i,
	output logic ara_cmd,
	output logic [7:0] got
);
	timeunit 1ns;
	timeprecision 100ps;
	logic rival_oe_n;
	assign sda_i = sda_oe_n & rival_oe_n;
	initial begin
		link_clk = 1'h1;
		rival_oe_n = 1'h1;
		ara_cmd = 1'h0;
		got = 8'h00;
	end
	task automatic ara();
		int i;
		#3 link_clk = 1'h0;
		repeat (4) @(negedge mclk);
		ara_cmd = 1'h1;
		@(negedge mclk) ara_cmd = 1'h0;
		for (i = 0; i < 9; i++) begin
			rival_oe_n = (i < 7) ? rival[6 - i] : 1'h1;
			#40 link_clk = 1'h1;
			if (i < 8)
				got = {got[6:0], sda_i};
			#40 link_clk = 1'h0;
		end
		#40 link_clk = 1'h1;
	endtask
endmodule // acac_host_model

// File: bench/tb.sv
// Self-checking bench of the conversion and alert control
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, resetn, ce, link_clk, sda_i, sda_o, sda_oe_n, cfg_wr;
	logic cfg_mode, cfg_os, cfg_window, cfg_pol, cfg_lat, result_rd;
	logic gcall_rst, ara_cmd, alert_o, alert_oe_n, os_flag, powered;
	logic conv_done, alert_state;
	logic [1:0] cfg_que;
	logic [2:0] cfg_dr;
	logic [6:0] target_addr, rival;
	logic [7:0] got;
	logic [11:0] cfg_hi, cfg_lo, adc_sample, result;
	int n_errors, n_checks, i, k;
	acac_ctrl #(.CLK_HZ(1000000)) dut_u (
		.mclk(mclk), .resetn(resetn), .ce(ce), .link_clk(link_clk),
		.sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
		.target_addr(target_addr), .cfg_wr(cfg_wr), .cfg_mode(cfg_mode),
		.cfg_os(cfg_os), .cfg_dr(cfg_dr), .cfg_window(cfg_window),
		.cfg_pol(cfg_pol), .cfg_lat(cfg_lat), .cfg_que(cfg_que),
		.cfg_hi(cfg_hi), .cfg_lo(cfg_lo), .result_rd(result_rd),
		.gcall_rst(gcall_rst), .ara_cmd(ara_cmd), .adc_sample(adc_sample),
		.alert_o(alert_o), .alert_oe_n(alert_oe_n), .result(result),
		.os_flag(os_flag), .powered(powered), .conv_done(conv_done),
		.alert_state(alert_state)
	);
	acac_host_model host_u (
		.mclk(mclk), .sda_oe_n(sda_oe_n), .rival(rival),
		.link_clk(link_clk), .sda_i(sda_i), .ara_cmd(ara_cmd), .got(got)
	);
	// ------------
	// Tasks
	// ------------
	task automatic chk(input logic [11:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic cfg(input logic m, o, w, p, l, input logic [1:0] q,
		input logic [11:0] h, lw);
		@(negedge mclk);
		{cfg_mode, cfg_os, cfg_window, cfg_pol, cfg_lat} = {m, o, w, p, l};
		{cfg_que, cfg_hi, cfg_lo} = {q, h, lw};
		cfg_wr = 1'h1;
		@(negedge mclk);
		cfg_wr = 1'h0;
	endtask
	task automatic wait_done();
		int j;
		for (j = 0; j < 700 && conv_done !== 1'h1; j++)
			@(negedge mclk);
		k = j;
		chk(conv_done, 1'h1);
	endtask
	task automatic shot(input logic [11:0] s, input logic w, p,
		input logic [1:0] q, input logic [11:0] h, lw);
		adc_sample = s;
		cfg(1'h1, 1'h1, w, p, 1'h1, q, h, lw);
		wait_done();
		repeat (3) @(negedge mclk);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ------------
	// Tests
	// ------------
	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end
	initial begin
		{ce, resetn, cfg_wr, result_rd, gcall_rst} = 5'h10;
		{cfg_mode, cfg_os, cfg_window, cfg_pol, cfg_lat} = 5'h10;
		{cfg_dr, cfg_que, cfg_hi, cfg_lo} = {3'h7, 2'h3, 12'h7FF, 12'h800};
		{adc_sample, target_addr, rival} = {12'h000, 7'h49, 7'h7F};
		repeat (12) @(negedge mclk);
		resetn = 1'h1;
		repeat (3) @(negedge mclk);
		chk(alert_oe_n, 1'h1);
		chk(sda_oe_n, 1'h1);
		chk(powered, 1'h0);
		$display("test reset done");
		cfg_dr = 3'h4;
		adc_sample = 12'h123;
		cfg(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 12'h7FF, 12'h800);
		repeat (40) @(negedge mclk);
		chk(os_flag, 1'h0);
		cfg(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 12'h7FF, 12'h800);
		wait_done();
		chk(result, 12'h123);
		repeat (20) @(negedge mclk);
		chk(powered, 1'h0);
		chk(alert_oe_n, 1'h1);
		$display("test single shot done");
		cfg_dr = 3'h7;
		for (i = 0; i < 3; i++) begin
			shot(12'h050, 1'h1, i == 1, (i == 2) ? 2'h3 : 2'h1, 12'h800, 12'h7FF);
			chk(alert_oe_n, i != 0);
		end
		$display("test ready pin done");
		adc_sample = 12'h321;
		cfg(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 12'h800, 12'h7FF);
		wait_done();
		k = 0;
		repeat (30) begin
			@(negedge mclk);
			k += (alert_oe_n === 1'h0);
		end
		chk(k, 8);
		chk(powered, 1'h1);
		chk(result, 12'h321);
		adc_sample = 12'h222;
		cfg(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 12'h800, 12'h7FF);
		wait_done();
		chk(k, 1000000 / 3300 - 32);
		chk(result, 12'h222);
		repeat (30) @(negedge mclk);
		chk(powered, 1'h0);
		cfg(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 12'h800, 12'h7FF);
		wait_done();
		@(negedge mclk) gcall_rst = 1'h1;
		@(negedge mclk) gcall_rst = 1'h0;
		repeat (400) @(negedge mclk);
		chk(powered, 1'h0);
		chk(alert_oe_n, 1'h1);
		$display("test continuous done");
		shot(12'h200, 1'h1, 1'h0, 2'h0, 12'h100, 12'h080);
		chk(alert_oe_n, 1'h0);
		chk(alert_state, 1'h1);
		rival = 7'h10;
		host_u.ara();
		repeat (5) @(negedge mclk);
		chk(alert_oe_n, 1'h0);
		rival = 7'h7F;
		host_u.ara();
		chk(got, {target_addr, 1'h1});
		chk(alert_oe_n, 1'h1);
		shot(12'h010, 1'h1, 1'h0, 2'h0, 12'h100, 12'h080);
		chk(alert_oe_n, 1'h0);
		host_u.ara();
		chk(got, {target_addr, 1'h0});
		shot(12'h200, 1'h1, 1'h0, 2'h0, 12'h100, 12'h080);
		@(negedge mclk) result_rd = 1'h1;
		@(negedge mclk) result_rd = 1'h0;
		repeat (2) @(negedge mclk);
		chk(alert_oe_n, 1'h1);
		chk(alert_state, 1'h0);
		$display("test alert response done");
		print_verdict();
	end
endmodule // tb

// File: core/acac_consts.vh
// Constants for the conversion sequencing and alert pin logic
`ifndef ACAC_CONSTS_VH
`define ACAC_CONSTS_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define ACAC_CLK_HZ 125000000
`define ACAC_WAKE_NS 25000
`define ACAC_RDY_NS 8000
`define ACAC_RATE0 128
`define ACAC_RATE1 250
`define ACAC_RATE2 490
`define ACAC_RATE3 920
`define ACAC_RATE4 1600
`define ACAC_RATE5 2400
`define ACAC_RATE6 3300
`define ACAC_RATE7 3300
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define ACAC_LIM_MSB 11
`define ACAC_QUE_OFF 2'h3
`define ACAC_QUE_ONE 2'h0
`define ACAC_QUE_TWO 2'h1
`define ACAC_ARA_LAST 4'h7
`define ACAC_ARA_DONE 4'h8
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACAC_MODE_RST 1'h1
`define ACAC_DR_RST 3'h4
`define ACAC_QUE_RST 2'h3
`define ACAC_POL_RST 1'h0
`define ACAC_LAT_RST 1'h0
`define ACAC_WIN_RST 1'h0
`define ACAC_HI_RST 12'h7FF
`define ACAC_LO_RST 12'h800
`endif

// File: core/acac_ctrl.v
// Conversion sequencing, comparator and open-drain alert pin control
`include "acac_consts.vh"
module acac_ctrl #(
	parameter CLK_HZ = `ACAC_CLK_HZ
) (
	mclk,
	resetn,
	ce,
	link_clk,
	sda_i,
	sda_o,
	sda_oe_n,
	target_addr,
	cfg_wr,
	cfg_mode,
	cfg_os,
	cfg_dr,
	cfg_window,
	cfg_pol,
	cfg_lat,
	cfg_que,
	cfg_hi,
	cfg_lo,
	result_rd,
	gcall_rst,
	ara_cmd,
	adc_sample,
	alert_o,
	alert_oe_n,
	result,
	os_flag,
	powered,
	conv_done,
	alert_state
);
	input wire mclk;
	input wire resetn;
	input wire ce;
	input wire link_clk;
	input wire sda_i;
	output reg sda_o;
	output reg sda_oe_n;
	input wire [6:0] target_addr;
	input wire cfg_wr;
	input wire cfg_mode;
	input wire cfg_os;
	input wire [2:0] cfg_dr;
	input wire cfg_window;
	input wire cfg_pol;
	input wire cfg_lat;
	input wire [1:0] cfg_que;
	input wire [11:0] cfg_hi;
	input wire [11:0] cfg_lo;
	input wire result_rd;
	input wire gcall_rst;
	input wire ara_cmd;
	input wire [11:0] adc_sample;
	output reg alert_o;
	output reg alert_oe_n;
	output reg [11:0] result;
	output reg os_flag;
	output reg powered;
	output reg conv_done;
	output reg alert_state;

	localparam ST_PDOWN = 2'h0;
	localparam ST_WAKE = 2'h1;
	localparam ST_CONV = 2'h2;
	localparam integer CLK_MHZ = CLK_HZ / 1000000;
	localparam integer WAKE_RAW = (`ACAC_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam integer RDY_RAW = (`ACAC_RDY_NS * CLK_MHZ + 999) / 1000;
	localparam [23:0] WAKE_CYC = (WAKE_RAW < 1) ? 24'h1 : WAKE_RAW[23:0];
	localparam [23:0] RDY_CYC = (RDY_RAW < 1) ? 24'h1 : RDY_RAW[23:0];

	// Cycles per conversion for a rate code
	function [23:0] conv_cyc;
		input [2:0] dr;
		integer n;
		begin
			case (dr)
				3'h0: n = CLK_HZ / `ACAC_RATE0;
				3'h1: n = CLK_HZ / `ACAC_RATE1;
				3'h2: n = CLK_HZ / `ACAC_RATE2;
				3'h3: n = CLK_HZ / `ACAC_RATE3;
				3'h4: n = CLK_HZ / `ACAC_RATE4;
				3'h5: n = CLK_HZ / `ACAC_RATE5;
				3'h6: n = CLK_HZ / `ACAC_RATE6;
				default: n = CLK_HZ / `ACAC_RATE7;
			endcase
			conv_cyc = (n < 1) ? 24'h1 : n[23:0];
		end
	endfunction

	// Readings needed before the alert asserts
	function [2:0] que_need;
		input [1:0] que;
		begin
			case (que)
				`ACAC_QUE_ONE: que_need = 3'h1;
				`ACAC_QUE_TWO: que_need = 3'h2;
				default: que_need = 3'h4;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Reset and input synchronisers
	// ----------------------------------------
	reg rst_meta_reg;
	reg rst_n_reg;
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	wire [8:0] pins_s;
	acac_sync #(.W(9), .RST(9'h180)) u_sync (
		.clk(mclk),
		.rst_n(rst_n_reg),
		.ce(ce),
		.d({link_clk, sda_i, target_addr}),
		.q(pins_s)
	);
	wire scl_s = pins_s[8];
	wire sda_s = pins_s[7];
	wire [6:0] addr_s = pins_s[6:0];

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [1:0] st_reg;
	reg [23:0] cnt_reg;
	reg sh_mode_reg, sh_win_reg, sh_pol_reg, sh_lat_reg;
	reg [2:0] sh_dr_reg;
	reg [1:0] sh_que_reg;
	reg [11:0] sh_hi_reg, sh_lo_reg;
	reg act_win_reg, act_pol_reg, act_lat_reg;
	reg [1:0] act_que_reg;
	reg [11:0] act_hi_reg, act_lo_reg;
	reg act_cont_reg;
	reg [2:0] que_cnt_reg;
	reg cmp_reg, hi_flag_reg, rdy_lvl_reg;
	reg [23:0] rdy_cnt_reg;
	reg scl_q_reg, ara_busy_reg;
	reg [3:0] ara_bits_reg;
	reg [7:0] ara_shift_reg;

	wire rdy_mode = act_hi_reg[`ACAC_LIM_MSB] & ~act_lo_reg[`ACAC_LIM_MSB];
	wire conv_end = (st_reg == ST_CONV) && (cnt_reg == 24'h1);
	wire above = $signed(adc_sample) > $signed(act_hi_reg);
	wire below = $signed(adc_sample) < $signed(act_lo_reg);
	wire beyond = act_win_reg ? (above | below) : above;
	wire [2:0] que_inc = (que_cnt_reg == 3'h4) ? 3'h4 : que_cnt_reg + 3'h1;
	wire scl_rise = scl_s & ~scl_q_reg;
	wire scl_fall = ~scl_s & scl_q_reg;
	wire ara_lose = ara_shift_reg[7] & ~sda_s;
	wire ara_win = ara_busy_reg & scl_rise & ~ara_lose
		& (ara_bits_reg == `ACAC_ARA_LAST);

	reg alert_act;
	always @* begin
		if (rdy_mode)
			alert_act = act_cont_reg ? (rdy_cnt_reg != 24'h0) : rdy_lvl_reg;
		else
			alert_act = cmp_reg;
	end

	// Defaults for power-up and general-call reset
	task load_defaults;
		begin
			st_reg <= ST_PDOWN;
			cnt_reg <= 24'h0;
			sh_mode_reg <= `ACAC_MODE_RST;
			sh_dr_reg <= `ACAC_DR_RST;
			sh_que_reg <= `ACAC_QUE_RST;
			sh_pol_reg <= `ACAC_POL_RST;
			sh_lat_reg <= `ACAC_LAT_RST;
			sh_win_reg <= `ACAC_WIN_RST;
			sh_hi_reg <= `ACAC_HI_RST;
			sh_lo_reg <= `ACAC_LO_RST;
			act_que_reg <= `ACAC_QUE_RST;
			act_pol_reg <= `ACAC_POL_RST;
			act_lat_reg <= `ACAC_LAT_RST;
			act_win_reg <= `ACAC_WIN_RST;
			act_hi_reg <= `ACAC_HI_RST;
			act_lo_reg <= `ACAC_LO_RST;
			act_cont_reg <= 1'b0;
			que_cnt_reg <= 3'h0;
			cmp_reg <= 1'b0;
			hi_flag_reg <= 1'b0;
			rdy_lvl_reg <= 1'b0;
			rdy_cnt_reg <= 24'h0;
			ara_busy_reg <= 1'b0;
			ara_bits_reg <= 4'h0;
			ara_shift_reg <= 8'h00;
			result <= 12'h000;
			os_flag <= 1'b0;
			powered <= 1'b0;
			conv_done <= 1'b0;
			alert_state <= 1'b0;
			alert_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
		end
	endtask

	// ----------------------------------------
	// Sequencer, comparator and alert response
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			load_defaults;
			scl_q_reg <= 1'b1;
			alert_o <= 1'b0;
			sda_o <= 1'b0;
		end else if (ce) begin
			scl_q_reg <= scl_s;
			alert_o <= 1'b0;
			sda_o <= 1'b0;
			if (gcall_rst) begin
				load_defaults;
			end else begin
				conv_done <= 1'b0;
				if (cfg_wr) begin
					sh_mode_reg <= cfg_mode;
					sh_dr_reg <= cfg_dr;
					sh_que_reg <= cfg_que;
					sh_pol_reg <= cfg_pol;
					sh_lat_reg <= cfg_lat;
					sh_win_reg <= cfg_window;
					sh_hi_reg <= cfg_hi;
					sh_lo_reg <= cfg_lo;
				end
				if (rdy_cnt_reg != 24'h0)
					rdy_cnt_reg <= rdy_cnt_reg - 24'h1;
				if (result_rd)
					cmp_reg <= 1'b0;
				if (ara_win) begin
					cmp_reg <= 1'b0;
					que_cnt_reg <= 3'h0;
				end
				case (st_reg)
					ST_PDOWN: begin
						powered <= 1'b0;
						if (cfg_wr && (!cfg_mode || cfg_os)) begin
							st_reg <= ST_WAKE;
							cnt_reg <= WAKE_CYC;
							os_flag <= cfg_mode & cfg_os;
							powered <= 1'b1;
						end else if (!sh_mode_reg) begin
							st_reg <= ST_WAKE;
							cnt_reg <= WAKE_CYC;
							powered <= 1'b1;
						end
					end
					ST_WAKE: begin
						if (cnt_reg == 24'h1) begin
							os_flag <= 1'b0;
							rdy_lvl_reg <= 1'b0;
							st_reg <= ST_CONV;
							cnt_reg <= conv_cyc(sh_dr_reg);
							act_que_reg <= sh_que_reg;
							act_pol_reg <= sh_pol_reg;
							act_lat_reg <= sh_lat_reg;
							act_win_reg <= sh_win_reg;
							act_hi_reg <= sh_hi_reg;
							act_lo_reg <= sh_lo_reg;
							act_cont_reg <= ~sh_mode_reg;
						end else
							cnt_reg <= cnt_reg - 24'h1;
					end
					ST_CONV: begin
						if (conv_end) begin
							result <= adc_sample;
							conv_done <= 1'b1;
							if (!sh_mode_reg) begin
								cnt_reg <= conv_cyc(sh_dr_reg);
								act_que_reg <= sh_que_reg;
								act_pol_reg <= sh_pol_reg;
								act_lat_reg <= sh_lat_reg;
								act_win_reg <= sh_win_reg;
								act_hi_reg <= sh_hi_reg;
								act_lo_reg <= sh_lo_reg;
								act_cont_reg <= 1'b1;
							end else begin
								st_reg <= ST_PDOWN;
								powered <= 1'b0;
							end
						end else
							cnt_reg <= cnt_reg - 24'h1;
					end
					default: st_reg <= ST_PDOWN;
				endcase
				if (conv_end && rdy_mode) begin
					if (act_cont_reg)
						rdy_cnt_reg <= RDY_CYC;
					else
						rdy_lvl_reg <= 1'b1;
				end else if (conv_end && act_que_reg != `ACAC_QUE_OFF) begin
					if (beyond) begin
						que_cnt_reg <= que_inc;
						if (que_inc >= que_need(act_que_reg)) begin
							cmp_reg <= 1'b1;
							hi_flag_reg <= above;
						end
					end else begin
						que_cnt_reg <= 3'h0;
						if (!act_lat_reg && (act_win_reg || below))
							cmp_reg <= 1'b0;
					end
				end
				if (!ara_busy_reg && ara_cmd && cmp_reg && act_lat_reg
						&& !rdy_mode) begin
					ara_busy_reg <= 1'b1;
					ara_bits_reg <= 4'h0;
					ara_shift_reg <= {addr_s, hi_flag_reg};
					sda_oe_n <= addr_s[6];
				end else if (ara_busy_reg) begin
					if (scl_rise) begin
						if (ara_lose) begin
							ara_busy_reg <= 1'b0;
							sda_oe_n <= 1'b1;
						end else
							ara_bits_reg <= ara_bits_reg + 4'h1;
					end else if (scl_fall) begin
						if (ara_bits_reg == `ACAC_ARA_DONE) begin
							ara_busy_reg <= 1'b0;
							sda_oe_n <= 1'b1;
						end else begin
							ara_shift_reg <= {ara_shift_reg[6:0], 1'b0};
							sda_oe_n <= ara_shift_reg[6];
						end
					end
				end
				alert_state <= alert_act;
				alert_oe_n <= (act_que_reg == `ACAC_QUE_OFF)
					| ~(alert_act ^ act_pol_reg);
			end
		end
	end
endmodule // acac_ctrl

// File: core/acac_sync.v
// Two-flop synchroniser for signals from outside the clock domain
module acac_sync #(
	parameter W = 1,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	clk,
	rst_n,
	ce,
	d,
	q
);
	input wire clk;
	input wire rst_n;
	input wire ce;
	input wire [W-1:0] d;
	output reg [W-1:0] q;

	reg [W-1:0] meta_reg;

	// ----------------------------------------
	// Two stages
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RST;
			q <= RST;
		end else if (ce) begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // acac_sync
